/* verilog/ubf_pkg.sv */
/*
 * ubf_pkg: register offsets, field positions, reset values and timing constants
 * for the serial baud and frame configuration block.
 * assumes a single 20 MHz system clock and a byte-wide register port.
 */
package ubf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned OVERSAMPLE     = 16;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [1:0] ADDR_BAUD_HIGH  = 2'h0;
    localparam logic [1:0] ADDR_BAUD_LOW   = 2'h1;
    localparam logic [1:0] ADDR_CTRL_ONE   = 2'h2;
    localparam logic [1:0] ADDR_STATUS     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // baud divisor high fields
    localparam int unsigned BDH_LIN_BRK_IE = 7;
    localparam int unsigned BDH_RX_EDGE_IE = 6;
    localparam int unsigned BDH_DIV_MSB    = 4;
    localparam int unsigned DIV_WIDTH      = 13;

    ////////////////////////////////////////////////////////////////////////////
    // control one fields
    localparam int unsigned C1_LOOP        = 7;
    localparam int unsigned C1_FREEZE      = 6;
    localparam int unsigned C1_RX_SRC      = 5;
    localparam int unsigned C1_NINE_BITS   = 4;
    localparam int unsigned C1_WAKE_ADDR   = 3;
    localparam int unsigned C1_IDLE_STOP   = 2;
    localparam int unsigned C1_PAR_EN      = 1;
    localparam int unsigned C1_PAR_ODD     = 0;

    ////////////////////////////////////////////////////////////////////////////
    // status fields
    localparam int unsigned ST_ARMED       = 0;
    localparam int unsigned ST_RUNNING     = 1;
    localparam int unsigned ST_RX_GPIO     = 2;
    localparam int unsigned ST_TX_DRIVE    = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] BDH_RESET       = 8'h00;
    localparam logic [7:0] BDL_RESET       = 8'h01;
    localparam logic [7:0] C1_RESET        = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // idle detection lengths in bit times
    localparam logic [3:0] IDLE_BITS_8     = 4'ha;
    localparam logic [3:0] IDLE_BITS_9     = 4'hb;

    ////////////////////////////////////////////////////////////////////////////
    // baud generator state
    typedef enum logic [2:0] {
        UBF_GEN_OFF   = 3'b001,
        UBF_GEN_RUN   = 3'b010,
        UBF_GEN_FROZE = 3'b100
    } ubf_gen_t;

endpackage : ubf_pkg

/* verilog/ubf_config.sv */
/*
 * ubf_config: baud rate generator and frame option registers of an
 * asynchronous serial transceiver, with loop and single-wire pin routing.
 * assumes the transmitter, receiver and second control register sit outside
 * and exchange enables, flags, characters and serial levels on plain ports.
 */
// Local design decisions: strobed register access and the register offsets.

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - high divisor write is buffered; working high loads on low write
// - low divisor resets non-zero; generator idle until rx or tx first enabled
// - divisor zero stops the baud generator completely
// - high bit 7 gates lin break flag onto its interrupt request
// - high bit 6 gates receive edge flag onto its interrupt request
// - loop select routes transmitter output to receiver, rx pin unused
// - loop clear gives full duplex on separate rx and tx pins
// - control bit 6 freezes serial clocks during cpu wait
// - receiver source bit ignored unless loop selected; then tx pin node
// - in loop, source 0 internal loop, source 1 single-wire on tx pin
// - control bit 4 selects 8 or 9 data bits, lsb first
// - control bit 3 selects idle-line or address-mark wakeup
// - idle needs 10 or 11 high bits, counted after start or stop
// - parity enable generates and checks parity in the top data bit
// - parity odd select: 0 even, 1 odd, parity bit counted
// - transmitter enabled takes the tx pin as a serial output
// - loop select returns rx pin to general purpose even with rx on
module ubf_config
    import ubf_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // enables and flags from the rest of the transceiver
    input  wire logic       tx_on,
    input  wire logic       rx_on,
    input  wire logic       lin_break_flag,
    input  wire logic       rx_edge_flag,
    input  wire logic       cpu_wait,
    // interrupt requests
    output logic            lin_break_irq,
    output logic            rx_edge_irq,
    // baud ticks
    output logic            baud_x16_tick,
    output logic            baud_bit_tick,
    // frame options to transmitter and receiver
    output logic            frame_nine_bits,
    output logic            wake_on_address,
    output logic            idle_count_from_stop,
    output logic      [3:0] idle_bit_count,
    output logic            parity_enable,
    output logic            parity_odd_select,
    // parity generation and check
    input  wire logic [8:0] tx_char,
    output logic            tx_parity_bit,
    input  wire logic [8:0] rx_char,
    input  wire logic       rx_char_valid,
    output logic            rx_parity_error,
    // serial routing
    input  wire logic       tx_serial_out,
    output logic            rx_serial_in,
    input  wire logic       rx_pin_in,
    input  wire logic       tx_pin_in,
    output logic            tx_pin_out,
    output logic            tx_pin_oe,
    output logic            rx_pin_gpio
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic char_parity(input logic [8:0] ch, input logic nine);
        logic [8:0] mask;
        mask = nine ? 9'h1ff : 9'h0ff;
        return ^(ch & mask);
    endfunction : char_parity

    function automatic logic [7:0] div_field(input logic [7:0] v);
        return {3'h0, v[BDH_DIV_MSB:0]};
    endfunction : div_field

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  bdh_buf_reg;
    logic [4:0]  div_high_reg;
    logic [7:0]  bdl_reg;
    logic [7:0]  ctrl_one_reg;
    logic        armed_reg;
    logic [12:0] div_count_reg;
    logic [3:0]  sub_count_reg;
    ubf_gen_t    gen_reg;
    ubf_gen_t    gen_next;
    logic [12:0] rate_divisor;
    logic        loopback_select;
    logic        rx_source_select;
    logic        freeze_in_wait;
    logic        lin_break_irq_en;
    logic        rx_edge_irq_en;

    assign rate_divisor     = {div_high_reg, bdl_reg};
    assign loopback_select  = ctrl_one_reg[C1_LOOP];
    assign rx_source_select = ctrl_one_reg[C1_RX_SRC];
    assign freeze_in_wait   = ctrl_one_reg[C1_FREEZE];
    assign lin_break_irq_en = bdh_buf_reg[BDH_LIN_BRK_IE];
    assign rx_edge_irq_en   = bdh_buf_reg[BDH_RX_EDGE_IE];

    ////////////////////////////////////////////////////////////////////////////
    // baud divisor registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bdh_buf_reg  <= BDH_RESET;
            div_high_reg <= BDH_RESET[BDH_DIV_MSB:0];
            bdl_reg      <= BDL_RESET;
        end else if (reg_write) begin
            if (reg_addr == ADDR_BAUD_HIGH) begin
                bdh_buf_reg <= reg_wdata;
            end
            if (reg_addr == ADDR_BAUD_LOW) begin
                bdl_reg      <= reg_wdata;
                div_high_reg <= bdh_buf_reg[BDH_DIV_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control one register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one_reg <= C1_RESET;
        end else if (reg_write && reg_addr == ADDR_CTRL_ONE) begin
            ctrl_one_reg <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // generator arming after first enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else if (tx_on || rx_on) begin
            armed_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // baud generator state
    always_comb begin
        gen_next = gen_reg;
        unique case (gen_reg)
            UBF_GEN_OFF: begin
                if (armed_reg && rate_divisor != 13'h0000) begin
                    gen_next = UBF_GEN_RUN;
                end
            end
            UBF_GEN_RUN: begin
                if (rate_divisor == 13'h0000) begin
                    gen_next = UBF_GEN_OFF;
                end else if (cpu_wait && freeze_in_wait) begin
                    gen_next = UBF_GEN_FROZE;
                end
            end
            UBF_GEN_FROZE: begin
                if (rate_divisor == 13'h0000) begin
                    gen_next = UBF_GEN_OFF;
                end else if (!(cpu_wait && freeze_in_wait)) begin
                    gen_next = UBF_GEN_RUN;
                end
            end
            default: begin
                gen_next = UBF_GEN_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_reg <= UBF_GEN_OFF;
        end else begin
            gen_reg <= gen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modulo divider: x16 tick every divisor clocks, bit tick every 16 of those
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count_reg <= 13'h0000;
            sub_count_reg <= 4'h0;
            baud_x16_tick <= 1'b0;
            baud_bit_tick <= 1'b0;
        end else if (gen_reg != UBF_GEN_RUN) begin
            div_count_reg <= 13'h0000;
            baud_x16_tick <= 1'b0;
            baud_bit_tick <= 1'b0;
            if (gen_reg == UBF_GEN_OFF) begin
                sub_count_reg <= 4'h0;
            end
        end else if (div_count_reg >= rate_divisor - 13'h0001) begin
            div_count_reg <= 13'h0000;
            baud_x16_tick <= 1'b1;
            sub_count_reg <= sub_count_reg + 4'h1;
            baud_bit_tick <= (sub_count_reg == 4'hf);
        end else begin
            div_count_reg <= div_count_reg + 13'h0001;
            baud_x16_tick <= 1'b0;
            baud_bit_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt requests
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lin_break_irq <= 1'b0;
            rx_edge_irq   <= 1'b0;
        end else begin
            lin_break_irq <= lin_break_irq_en && lin_break_flag;
            rx_edge_irq   <= rx_edge_irq_en && rx_edge_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame options
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_nine_bits      <= 1'b0;
            wake_on_address      <= 1'b0;
            idle_count_from_stop <= 1'b0;
            idle_bit_count       <= IDLE_BITS_8;
            parity_enable        <= 1'b0;
            parity_odd_select    <= 1'b0;
        end else begin
            frame_nine_bits      <= ctrl_one_reg[C1_NINE_BITS];
            wake_on_address      <= ctrl_one_reg[C1_WAKE_ADDR];
            idle_count_from_stop <= ctrl_one_reg[C1_IDLE_STOP];
            idle_bit_count       <= ctrl_one_reg[C1_NINE_BITS] ? IDLE_BITS_9
                                                                : IDLE_BITS_8;
            parity_enable        <= ctrl_one_reg[C1_PAR_EN];
            parity_odd_select    <= ctrl_one_reg[C1_PAR_ODD];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parity: top data bit carries it; total ones even or odd
    logic       nine_now;
    logic [8:0] tx_low_bits;

    assign nine_now    = ctrl_one_reg[C1_NINE_BITS];
    assign tx_low_bits = nine_now ? {1'b0, tx_char[7:0]} : {2'b00, tx_char[6:0]};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_parity_bit   <= 1'b0;
            rx_parity_error <= 1'b0;
        end else begin
            tx_parity_bit <= char_parity(tx_low_bits, 1'b1)
                             ^ ctrl_one_reg[C1_PAR_ODD];
            rx_parity_error <= rx_char_valid && ctrl_one_reg[C1_PAR_EN]
                               && (char_parity(rx_char, nine_now)
                                   != ctrl_one_reg[C1_PAR_ODD]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin routing; idle level high when transmitter output is off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_serial_in <= 1'b1;
            tx_pin_out   <= 1'b1;
            tx_pin_oe    <= 1'b0;
            rx_pin_gpio  <= 1'b1;
        end else begin
            if (!loopback_select) begin
                rx_serial_in <= rx_pin_in;
            end else if (!rx_source_select) begin
                rx_serial_in <= tx_serial_out;
            end else begin
                rx_serial_in <= tx_pin_in;
            end
            tx_pin_out  <= tx_on ? tx_serial_out : 1'b1;
            tx_pin_oe   <= tx_on;
            rx_pin_gpio <= !(rx_on && !loopback_select);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_BAUD_HIGH: reg_rdata <= {bdh_buf_reg[7:6], 6'h00}
                                             | div_field(bdh_buf_reg);
                ADDR_BAUD_LOW:  reg_rdata <= bdl_reg;
                ADDR_CTRL_ONE:  reg_rdata <= ctrl_one_reg;
                ADDR_STATUS:    reg_rdata <= {4'h0, tx_pin_oe, rx_pin_gpio,
                                              gen_reg == UBF_GEN_RUN, armed_reg};
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    a_high_buffered: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_write && reg_addr == ADDR_BAUD_HIGH |=> $stable(div_high_reg))
        else $error("working high divisor changed on high write");
    a_high_on_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_write && reg_addr == ADDR_BAUD_LOW
        |=> div_high_reg == $past(bdh_buf_reg[BDH_DIV_MSB:0]))
        else $error("working high divisor not loaded on low write");
    a_gen_unarmed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !armed_reg |-> !baud_x16_tick && gen_reg == UBF_GEN_OFF)
        else $error("baud generator ran before first enable");
    a_zero_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rate_divisor == 13'h0000 [*2] |-> !baud_x16_tick)
        else $error("baud tick with zero divisor");
    a_tick_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
        baud_x16_tick && gen_reg == UBF_GEN_RUN && rate_divisor == 13'h0002
        && $stable(rate_divisor) ##1 gen_reg == UBF_GEN_RUN && $stable(rate_divisor)
        |=> baud_x16_tick || gen_reg != UBF_GEN_RUN || !$stable(rate_divisor))
        else $error("x16 tick period wrong for divisor two");
    a_lin_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lin_break_irq == $past(lin_break_irq_en && lin_break_flag) || $past(!rst_n))
        else $error("lin break request mismatch");
    a_edge_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rx_edge_flag && rx_edge_irq_en |=> rx_edge_irq)
        else $error("rx edge request missing");
    a_loop_internal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        loopback_select && !rx_source_select |=> rx_serial_in == $past(tx_serial_out))
        else $error("internal loop not routed");
    a_full_duplex: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !loopback_select |=> rx_serial_in == $past(rx_pin_in))
        else $error("receiver not on rx pin");
    a_wait_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_wait && freeze_in_wait ##1 cpu_wait && freeze_in_wait |=> !baud_x16_tick)
        else $error("baud tick while frozen in wait");
    a_single_wire: assert property (@(posedge sys_clk) disable iff (!rst_n)
        loopback_select && rx_source_select |=> rx_serial_in == $past(tx_pin_in))
        else $error("single wire receiver not on tx pin");
    a_tx_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_on |=> tx_pin_oe ##0 tx_pin_out == $past(tx_serial_out))
        else $error("tx pin not driven by transmitter");
    a_rx_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        loopback_select |=> rx_pin_gpio)
        else $error("rx pin held in loop mode");
    a_parity_check: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ctrl_one_reg[C1_PAR_EN] |=> !rx_parity_error)
        else $error("parity error with parity disabled");
    c_divisor_update: cover property (@(posedge sys_clk) disable iff (!rst_n)
        reg_write && reg_addr == ADDR_BAUD_HIGH ##[1:4]
        reg_write && reg_addr == ADDR_BAUD_LOW);
    c_bit_tick: cover property (@(posedge sys_clk) disable iff (!rst_n) baud_bit_tick);
    c_single_wire: cover property (@(posedge sys_clk) disable iff (!rst_n)
        loopback_select && rx_source_select && tx_on);
    c_frozen: cover property (@(posedge sys_clk) disable iff (!rst_n)
        gen_reg == UBF_GEN_FROZE);
endmodule : ubf_config

/* test/ubf_remote_model.sv */
/*
 * ubf_remote_model: far serial partner on the rx and tx pins.
 * assumes the bench sets the level that the partner drives onto the rx line.
 */
module ubf_remote_model (
    // from the bench
    input  wire logic line_level,
    // pins of the block
    input  wire logic tx_pin_out,
    input  wire logic tx_pin_oe,
    output logic      rx_pin_in,
    output logic      tx_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////////
    // partner drives the rx line, pull-up holds the tx line high when released
    assign rx_pin_in = line_level;
    assign tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;
endmodule : ubf_remote_model

/* test/tb.sv */
/*
 * tb: self-checking bench for the baud and frame configuration block.
 * assumes one 20 MHz clock and the partner model on the serial pins.
 */
module tb
    import ubf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk, rst_n, reg_write, reg_read, tx_on, rx_on, cpu_wait;
    logic       lin_break_flag, rx_edge_flag, lin_break_irq, rx_edge_irq;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       baud_x16_tick, baud_bit_tick, frame_nine_bits, wake_on_address;
    logic       idle_count_from_stop, parity_enable, parity_odd_select;
    logic [3:0] idle_bit_count;
    logic [8:0] tx_char, rx_char;
    logic       tx_parity_bit, rx_char_valid, rx_parity_error, tx_serial_out;
    logic       rx_serial_in, rx_pin_in, tx_pin_in, tx_pin_out, tx_pin_oe;
    logic       rx_pin_gpio, line_level;
    int         n_mismatch, total_checks;
    int         nx, nb;

    ////////////////////////////////////////////////////////////////////////////
    ubf_config dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_on(tx_on), .rx_on(rx_on),
        .lin_break_flag(lin_break_flag), .rx_edge_flag(rx_edge_flag), .cpu_wait(cpu_wait),
        .lin_break_irq(lin_break_irq), .rx_edge_irq(rx_edge_irq),
        .baud_x16_tick(baud_x16_tick), .baud_bit_tick(baud_bit_tick),
        .frame_nine_bits(frame_nine_bits), .wake_on_address(wake_on_address),
        .idle_count_from_stop(idle_count_from_stop), .idle_bit_count(idle_bit_count),
        .parity_enable(parity_enable), .parity_odd_select(parity_odd_select),
        .tx_char(tx_char), .tx_parity_bit(tx_parity_bit), .rx_char(rx_char),
        .rx_char_valid(rx_char_valid), .rx_parity_error(rx_parity_error),
        .tx_serial_out(tx_serial_out), .rx_serial_in(rx_serial_in),
        .rx_pin_in(rx_pin_in), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
        .tx_pin_oe(tx_pin_oe), .rx_pin_gpio(rx_pin_gpio));
    ubf_remote_model remote (.line_level(line_level), .tx_pin_out(tx_pin_out),
        .tx_pin_oe(tx_pin_oe), .rx_pin_in(rx_pin_in), .tx_pin_in(tx_pin_in));

    always #25 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk("reg_rdata", {1'b0, exp}, {1'b0, reg_rdata});
    endtask : rd

    task automatic ticks(input int n);
        nx = 0;
        nb = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            nx += int'(baud_x16_tick === 1'b1);
            nb += int'(baud_bit_tick === 1'b1);
        end
    endtask : ticks

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(ADDR_BAUD_HIGH, BDH_RESET);
        rd(ADDR_BAUD_LOW, BDL_RESET);
        rd(ADDR_CTRL_ONE, C1_RESET);
        rd(ADDR_STATUS, 8'h04);
        ticks(100);
        chk("x16 ticks unarmed", 9'h0, 9'(nx));
    endtask : t_reset

    task automatic t_baud;
        @(posedge sys_clk);
        tx_on <= 1'b1;
        wr(ADDR_BAUD_HIGH, 8'h00);
        wr(ADDR_BAUD_LOW, 8'h02);
        repeat (40) @(posedge sys_clk);
        ticks(64);
        chk("x16 ticks div2", 9'd32, 9'(nx));
        chk("bit ticks div2", 9'd2, 9'(nb));
        wr(ADDR_BAUD_HIGH, 8'h01);
        repeat (40) @(posedge sys_clk);
        ticks(64);
        chk("x16 ticks high buffered", 9'd32, 9'(nx));
        rd(ADDR_BAUD_HIGH, 8'h01);
        wr(ADDR_BAUD_LOW, 8'h00);
        repeat (600) @(posedge sys_clk);
        ticks(512);
        chk("x16 ticks div256", 9'd2, 9'(nx));
        wr(ADDR_BAUD_HIGH, 8'h00);
        wr(ADDR_BAUD_LOW, 8'h00);
        repeat (10) @(posedge sys_clk);
        ticks(600);
        chk("x16 ticks div0", 9'h0, 9'(nx));
        wr(ADDR_BAUD_LOW, 8'h01);
        repeat (10) @(posedge sys_clk);
        ticks(32);
        chk("x16 ticks div1", 9'd32, 9'(nx));
        chk("bit ticks div1", 9'd2, 9'(nb));
    endtask : t_baud

    task automatic t_wait;
        @(posedge sys_clk);
        cpu_wait <= 1'b1;
        wr(ADDR_CTRL_ONE, 8'h40);
        repeat (5) @(posedge sys_clk);
        ticks(50);
        chk("x16 ticks frozen", 9'h0, 9'(nx));
        wr(ADDR_CTRL_ONE, 8'h00);
        repeat (5) @(posedge sys_clk);
        ticks(32);
        chk("x16 ticks wait run", 9'd32, 9'(nx));
        @(posedge sys_clk);
        cpu_wait <= 1'b0;
    endtask : t_wait

    task automatic t_irq;
        logic [7:0] v [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
        lin_break_flag <= 1'b1;
        rx_edge_flag   <= 1'b1;
        foreach (v[i]) begin
            wr(ADDR_BAUD_HIGH, v[i]);
            wr(ADDR_BAUD_LOW, 8'h01);
            repeat (3) @(posedge sys_clk);
            #1;
            chk("lin_break_irq", {8'h0, v[i][7]}, {8'h0, lin_break_irq});
            chk("rx_edge_irq", {8'h0, v[i][6]}, {8'h0, rx_edge_irq});
        end
        @(posedge sys_clk);
        lin_break_flag <= 1'b0;
        rx_edge_flag   <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("irqs flags low", 9'h0, {7'h0, lin_break_irq, rx_edge_irq});
    endtask : t_irq

    task automatic t_frame;
        logic [7:0] v [7] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h1f, 8'h00};
        foreach (v[i]) begin
            wr(ADDR_CTRL_ONE, v[i]);
            rd(ADDR_CTRL_ONE, v[i]);
            chk("frame options", {v[i][4:0], v[i][4] ? IDLE_BITS_9 : IDLE_BITS_8},
                {frame_nine_bits, wake_on_address, idle_count_from_stop, parity_enable,
                 parity_odd_select, idle_bit_count});
        end
    endtask : t_frame

    task automatic t_parity;
        logic [7:0] c [5] = '{8'h02, 8'h03, 8'h12, 8'h13, 8'h02};
        logic [8:0] d [5] = '{9'h007, 9'h007, 9'h0ff, 9'h0ff, 9'h000};
        logic       p [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        logic [7:0] rc [3] = '{8'h02, 8'h02, 8'h03};
        logic [8:0] rd_ch [3] = '{9'h081, 9'h080, 9'h080};
        logic       e [3] = '{1'b0, 1'b1, 1'b0};
        foreach (c[i]) begin
            wr(ADDR_CTRL_ONE, c[i]);
            tx_char <= d[i];
            repeat (3) @(posedge sys_clk);
            #1;
            chk("tx_parity_bit", {8'h0, p[i]}, {8'h0, tx_parity_bit});
        end
        foreach (rc[i]) begin
            wr(ADDR_CTRL_ONE, rc[i]);
            rx_char       <= rd_ch[i];
            repeat (2) @(posedge sys_clk);
            rx_char_valid <= 1'b1;
            @(posedge sys_clk);
            rx_char_valid <= 1'b0;
            #1 chk("rx_parity_error", {8'h0, e[i]}, {8'h0, rx_parity_error});
        end
    endtask : t_parity

    task automatic t_route;
        logic [7:0] m [4] = '{8'h00, 8'h20, 8'h80, 8'ha0};
        @(posedge sys_clk);
        rx_on <= 1'b1;
        foreach (m[i]) begin
            wr(ADDR_CTRL_ONE, m[i]);
            for (int b = 0; b < 2; b++) begin
                @(posedge sys_clk);
                line_level    <= 1'(b);
                tx_serial_out <= ~1'(b);
                repeat (3) @(posedge sys_clk);
                #1;
                chk("rx_serial_in", {8'h0, m[i][7] ? ~1'(b) : 1'(b)},
                    {8'h0, rx_serial_in});
                chk("rx_pin_gpio", {8'h0, m[i][7]}, {8'h0, rx_pin_gpio});
                chk("tx pin drive", {7'h0, 1'b1, ~1'(b)},
                    {7'h0, tx_pin_oe, tx_pin_out});
            end
        end
    endtask : t_route

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_clk, rst_n, reg_write, reg_read, tx_on, rx_on, cpu_wait} = '0;
        {lin_break_flag, rx_edge_flag, rx_char_valid} = '0;
        {reg_addr, reg_wdata, tx_char, rx_char} = '0;
        tx_serial_out = 1'b1;
        line_level    = 1'b1;
        n_mismatch    = 0;
        total_checks  = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_baud();
        t_wait();
        t_irq();
        t_frame();
        t_parity();
        t_route();
        final_report();
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        final_report();
    end
endmodule : tb
